//--- rtl/scsp_command_processor.sv
`timescale 1ns/1ns
`include "scsp_map.svh"

module scsp_command_processor #(
    parameter int unsigned REC_PERIOD_CYC = `SCSP_REC_CYC,
    parameter int unsigned TICK_CYC       = `SCSP_TICK_CYC
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         rxd,
    input  wire logic [3:0]   payloadId,
    input  wire logic [255:0] adcChan,
    input  wire logic [63:0]  regVolt,
    input  wire logic [63:0]  tempVal,
    input  wire logic [63:0]  errCode,
    input  wire logic         singleEvent,
    input  wire logic         doubleEvent,
    output logic              txd,
    output logic [7:0]        regRestart,
    output logic [7:0]        regDisable,
    output logic [7:0]        thermRestart,
    output logic [7:0]        thermDisable,
    output logic              adcResetStart,
    output logic              adcDisable,
    output logic              sysReboot,
    output logic              cmdAccepted,
    output logic              cmdRejected,
    output logic              recordBusy
);

    // tick length is a parameter so a short bit time can be run end to end
    localparam logic [10:0] TICK_LAST = 11'(TICK_CYC - 1);
    localparam logic [31:0] REC_LAST  = 32'(REC_PERIOD_CYC - 1);

    // command checksum: xor of payload nibble and both value nibbles
    function automatic logic [3:0] cmdSum(input logic [3:0] pay, input logic [7:0] val);
        cmdSum = pay ^ val[7:4] ^ val[3:0];
    endfunction

    // byte n of the record image, byte 0 in the top bits
    function automatic logic [7:0] recByte(input logic [703:0] img, input logic [6:0] idx);
        logic [703:0] sh;
        sh = img << {idx, 3'b000};
        recByte = sh[703:696];
    endfunction

    logic [10:0]                    tickCnt;
    logic                           ovsTick;
    logic                           rxS1;
    logic                           rxS2;
    logic                           rxS3;
    logic                           rxLine;
    scsp_pkg::scsp_rx_state_t       rxState;
    logic [1:0]                     rxPh;
    logic [2:0]                     rxBit;
    logic [7:0]                     rxShift;
    logic [7:0]                     rxByte;
    logic                           rxValid;
    logic [47:0]                    frameWin;
    logic [55:0]                    cand;
    logic [7:0]                     cmdB1;
    logic [7:0]                     cmdB2;
    logic                           frameHit;
    logic                           cmdGood;
    logic [15:0]                    lastCmd;
    logic [15:0]                    execStatus;
    logic                           txStart;
    logic [7:0]                     txByte;
    logic                           txBusy;
    logic [9:0]                     txShift;
    logic [3:0]                     txBitCnt;
    logic [1:0]                     txPh;
    logic [31:0]                    recTimer;
    logic                           recDue;
    scsp_pkg::scsp_rec_state_t      recState;
    logic [6:0]                     recIdx;
    logic [31:0]                    recSum;
    logic [31:0]                    seqNum;
    logic [47:0]                    singleCnt;
    logic [47:0]                    doubleCnt;
    logic [47:0]                    snapSingle;
    logic [47:0]                    snapDouble;
    logic [703:0]                   recImg;
    logic                           ramWrEn;
    logic [6:0]                     ramWrAddr;
    logic [7:0]                     ramWrData;
    logic [7:0]                     ramRdData;

    // oversample tick, four per bit period
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tickCnt <= 11'h000;
            ovsTick <= 1'b0;
        end else if (tickCnt == TICK_LAST) begin
            tickCnt <= 11'h000;
            ovsTick <= 1'b1;
        end else begin
            tickCnt <= tickCnt + 11'h001;
            ovsTick <= 1'b0;
        end
    end

    // three-stage pin synchronizer; level moves only when stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rxS1   <= 1'b1;
            rxS2   <= 1'b1;
            rxS3   <= 1'b1;
            rxLine <= 1'b1;
        end else begin
            rxS1 <= rxd;
            rxS2 <= rxS1;
            rxS3 <= rxS2;
            if (rxS2 == rxS3) begin
                rxLine <= rxS3;
            end
        end
    end

    // receiver: start edge realigns the sample phase, so clock drift does not accumulate
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rxState <= scsp_pkg::RX_IDLE;
            rxPh    <= 2'h0;
            rxBit   <= 3'h0;
            rxShift <= 8'h00;
            rxByte  <= 8'h00;
            rxValid <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            if (ovsTick) begin
                case (rxState)
                    scsp_pkg::RX_IDLE: begin
                        rxPh <= 2'h0;
                        if (!rxLine) begin
                            rxState <= scsp_pkg::RX_START;
                        end
                    end
                    scsp_pkg::RX_START: begin
                        rxPh <= rxPh + 2'h1;
                        if (rxPh == 2'h1) begin
                            rxPh    <= 2'h0;
                            rxBit   <= 3'h0;
                            // glitch shorter than half a bit goes back to idle
                            rxState <= rxLine ? scsp_pkg::RX_IDLE : scsp_pkg::RX_DATA;
                        end
                    end
                    scsp_pkg::RX_DATA: begin
                        rxPh <= rxPh + 2'h1;
                        if (rxPh == 2'h3) begin
                            rxShift <= {rxLine, rxShift[7:1]}; // lsb first
                            rxBit   <= rxBit + 3'h1;
                            if (rxBit == 3'h7) begin
                                rxState <= scsp_pkg::RX_STOP;
                            end
                        end
                    end
                    scsp_pkg::RX_STOP: begin
                        rxPh <= rxPh + 2'h1;
                        if (rxPh == 2'h3) begin
                            rxState <= scsp_pkg::RX_IDLE;
                            if (rxLine) begin
                                rxByte  <= rxShift;
                                rxValid <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        rxState <= scsp_pkg::RX_IDLE;
                    end
                endcase
            end
        end
    end

    // sliding seven-byte window; a frame is checked as its last byte lands
    assign cand     = {frameWin, rxByte};
    assign cmdB1    = cand[39:32];
    assign cmdB2    = cand[31:24];
    assign frameHit = (cand[55:48] == `SCSP_FRM_SOH) && (cand[47:40] == `SCSP_FRM_STX)
                   && (cand[23:16] == `SCSP_FRM_ETX) && (cand[15:8] == `SCSP_FRM_CR)
                   && (cand[7:0] == `SCSP_FRM_LF);
    assign cmdGood  = (cmdB1[`SCSP_PAYLOAD_LSB +: 4] == payloadId)
                   && (cmdB1[`SCSP_CSUM_LSB +: 4] == cmdSum(payloadId, cmdB2));

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frameWin <= 48'h0000_0000_0000;
        end else if (rxValid) begin
            frameWin <= cand[47:0];
        end
    end

    // command decode and one-cycle action pulses
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regRestart    <= 8'h00;
            regDisable    <= 8'h00;
            thermRestart  <= 8'h00;
            thermDisable  <= 8'h00;
            adcResetStart <= 1'b0;
            adcDisable    <= 1'b0;
            sysReboot     <= 1'b0;
            cmdAccepted   <= 1'b0;
            cmdRejected   <= 1'b0;
            lastCmd       <= 16'h0000;
            execStatus    <= `SCSP_EXEC_NONE;
        end else begin
            regRestart    <= 8'h00;
            regDisable    <= 8'h00;
            thermRestart  <= 8'h00;
            thermDisable  <= 8'h00;
            adcResetStart <= 1'b0;
            adcDisable    <= 1'b0;
            sysReboot     <= 1'b0;
            cmdAccepted   <= 1'b0;
            cmdRejected   <= 1'b0;
            if (rxValid && frameHit) begin
                lastCmd <= {cmdB1, cmdB2};
                if (!cmdGood) begin
                    cmdRejected <= 1'b1;
                    execStatus  <= `SCSP_EXEC_NONE;
                end else begin
                    cmdAccepted <= 1'b1;
                    execStatus  <= `SCSP_EXEC_DONE;
                    if (cmdB2 == `SCSP_CMD_REBOOT) begin
                        sysReboot <= 1'b1;
                    end else begin
                        case (cmdB2[`SCSP_GRP_LSB +: 4])
                            `SCSP_GRP_REG: begin
                                regRestart[cmdB2[`SCSP_ID_LSB +: 3]] <= cmdB2[`SCSP_STATE_BIT];
                                regDisable[cmdB2[`SCSP_ID_LSB +: 3]] <= !cmdB2[`SCSP_STATE_BIT];
                            end
                            `SCSP_GRP_THERM: begin
                                thermRestart[cmdB2[`SCSP_ID_LSB +: 3]] <= cmdB2[`SCSP_STATE_BIT];
                                thermDisable[cmdB2[`SCSP_ID_LSB +: 3]] <= !cmdB2[`SCSP_STATE_BIT];
                            end
                            `SCSP_GRP_ADC: begin
                                if (cmdB2[3:0] == `SCSP_ADC_ON) begin
                                    adcResetStart <= 1'b1;
                                end else if (cmdB2[3:0] == `SCSP_ADC_OFF) begin
                                    adcDisable <= 1'b1;
                                end else begin
                                    execStatus <= `SCSP_EXEC_NOOP;
                                end
                            end
                            default: begin
                                execStatus <= `SCSP_EXEC_NOOP;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // transmitter: four ticks per bit, start and stop framing
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            txd      <= 1'b1;
            txBusy   <= 1'b0;
            txShift  <= 10'h3ff;
            txBitCnt <= 4'h0;
            txPh     <= 2'h0;
        end else if (!txBusy) begin
            txd <= 1'b1;
            if (txStart) begin
                txShift  <= {1'b1, txByte, 1'b0};
                txBitCnt <= 4'h0;
                txPh     <= 2'h0;
                txBusy   <= 1'b1;
            end
        end else if (ovsTick) begin
            txd  <= txShift[0];
            txPh <= txPh + 2'h1;
            if (txPh == 2'h3) begin
                txShift  <= {1'b1, txShift[9:1]};
                txBitCnt <= txBitCnt + 4'h1;
                if (txBitCnt == 4'h9) begin
                    txBusy <= 1'b0;
                end
            end
        end
    end

    // ten second record period
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            recTimer <= 32'h0000_0000;
            recDue   <= 1'b0;
        end else if (recTimer == REC_LAST) begin
            recTimer <= 32'h0000_0000;
            recDue   <= 1'b1;
        end else begin
            recTimer <= recTimer + 32'h0000_0001;
            if (recState == scsp_pkg::REC_IDLE) begin
                recDue <= 1'b0;
            end
        end
    end

    // interval counters; an event in the snapshot cycle opens the new interval
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            singleCnt  <= 48'h0000_0000_0000;
            doubleCnt  <= 48'h0000_0000_0000;
            snapSingle <= 48'h0000_0000_0000;
            snapDouble <= 48'h0000_0000_0000;
        end else if (recDue && recState == scsp_pkg::REC_IDLE) begin
            snapSingle <= singleCnt;
            snapDouble <= doubleCnt;
            singleCnt  <= {47'h0, singleEvent};
            doubleCnt  <= {47'h0, doubleEvent};
        end else begin
            singleCnt <= singleCnt + {47'h0, singleEvent};
            doubleCnt <= doubleCnt + {47'h0, doubleEvent};
        end
    end

    // record image; regulator readings sit in the low half of four-byte slots
    assign recImg = {seqNum, 32'h0000_0000, adcChan,
                     16'h0000, regVolt[63:48], 16'h0000, regVolt[47:32],
                     16'h0000, regVolt[31:16], 16'h0000, regVolt[15:0], tempVal,
                     snapSingle, snapDouble, errCode, lastCmd, execStatus};

    // record sequencer: fill buffer, patch checksum, then stream out
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            recState   <= scsp_pkg::REC_IDLE;
            recIdx     <= 7'h00;
            recSum     <= 32'h0000_0000;
            seqNum     <= `SCSP_RST_SEQ;
            ramWrEn    <= 1'b0;
            ramWrAddr  <= 7'h00;
            ramWrData  <= 8'h00;
            txStart    <= 1'b0;
            txByte     <= 8'h00;
            recordBusy <= 1'b0;
        end else begin
            ramWrEn <= 1'b0;
            txStart <= 1'b0;
            case (recState)
                scsp_pkg::REC_IDLE: begin
                    recordBusy <= 1'b0;
                    recIdx     <= 7'h00;
                    recSum     <= 32'h0000_0000;
                    if (recDue) begin
                        recordBusy <= 1'b1;
                        recState   <= scsp_pkg::REC_FILL;
                    end
                end
                scsp_pkg::REC_FILL: begin
                    // live inputs are sampled across 88 cycles, not one instant
                    ramWrEn   <= 1'b1;
                    ramWrAddr <= recIdx;
                    ramWrData <= recByte(recImg, recIdx);
                    recSum    <= recSum + {24'h0, recByte(recImg, recIdx)};
                    recIdx    <= recIdx + 7'h01;
                    if (recIdx == `SCSP_REC_LAST) begin
                        recIdx   <= `SCSP_CSUM_BYTE;
                        recState <= scsp_pkg::REC_CSUM;
                    end
                end
                scsp_pkg::REC_CSUM: begin
                    ramWrEn   <= 1'b1;
                    ramWrAddr <= recIdx;
                    ramWrData <= recByte({recSum, 672'h0}, recIdx - `SCSP_CSUM_BYTE);
                    recIdx    <= recIdx + 7'h01;
                    if (recIdx == `SCSP_CSUM_LAST) begin
                        recIdx   <= 7'h00;
                        recState <= scsp_pkg::REC_REQ;
                    end
                end
                scsp_pkg::REC_REQ: begin
                    recState <= scsp_pkg::REC_LOAD; // read data lands next cycle
                end
                scsp_pkg::REC_LOAD: begin
                    if (!txBusy && !txStart) begin
                        txStart <= 1'b1;
                        txByte  <= ramRdData;
                        recIdx  <= recIdx + 7'h01;
                        if (recIdx == `SCSP_REC_LAST) begin
                            seqNum   <= seqNum + 32'h0000_0001;
                            recState <= scsp_pkg::REC_IDLE;
                        end else begin
                            recState <= scsp_pkg::REC_REQ;
                        end
                    end
                end
                default: begin
                    recState <= scsp_pkg::REC_IDLE;
                end
            endcase
        end
    end

    scsp_record_ram u_ram (
        .ref_clk (ref_clk),
        .wrEn    (ramWrEn),
        .wrAddr  (ramWrAddr),
        .wrData  (ramWrData),
        .rdAddr  (recIdx),
        .rdData  (ramRdData)
    );

endmodule

//--- rtl/scsp_map.svh
`ifndef SCSP_MAP_SVH
`define SCSP_MAP_SVH

// link timing
`define SCSP_CLK_HZ        25000000
`define SCSP_BAUD          4800
`define SCSP_OVS           4
`define SCSP_TICK_CYC      (`SCSP_CLK_HZ / (`SCSP_BAUD * `SCSP_OVS))
`define SCSP_REC_PERIOD_S  10
`define SCSP_REC_CYC       (`SCSP_CLK_HZ * `SCSP_REC_PERIOD_S)

// command framing
`define SCSP_FRM_SOH       8'h01
`define SCSP_FRM_STX       8'h02
`define SCSP_FRM_ETX       8'h03
`define SCSP_FRM_CR        8'h0d
`define SCSP_FRM_LF        8'h0a

// command byte 1 fields
`define SCSP_CSUM_LSB      0
`define SCSP_PAYLOAD_LSB   4

// command value fields and codes
`define SCSP_GRP_LSB       4
`define SCSP_STATE_BIT     3
`define SCSP_ID_LSB        0
`define SCSP_GRP_REG       4'h0
`define SCSP_GRP_THERM     4'h1
`define SCSP_GRP_ADC       4'h2
`define SCSP_CMD_REBOOT    8'hfa
`define SCSP_ADC_ON        4'h1
`define SCSP_ADC_OFF       4'h0

// execution status codes
`define SCSP_EXEC_NONE     16'h0000
`define SCSP_EXEC_DONE     16'h0001
`define SCSP_EXEC_NOOP     16'h0002

// status record layout
`define SCSP_REC_BYTES     88
`define SCSP_REC_LAST      7'd87
`define SCSP_CSUM_BYTE     7'd4
`define SCSP_CSUM_LAST     7'd7

// reset values
`define SCSP_RST_SEQ       32'h0000_0000

`endif

//--- rtl/scsp_pkg.sv
package scsp_pkg;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } scsp_rx_state_t;

    typedef enum logic [2:0] {
        REC_IDLE,
        REC_FILL,
        REC_CSUM,
        REC_REQ,
        REC_LOAD
    } scsp_rec_state_t;

endpackage

//--- rtl/scsp_record_ram.sv
`timescale 1ns/1ns

module scsp_record_ram (
    input  wire logic       ref_clk,
    input  wire logic       wrEn,
    input  wire logic [6:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic [6:0] rdAddr,
    output logic      [7:0] rdData
);

    logic [7:0] mem [0:87];

    // one write port, registered read
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule

//--- tb/scsp_command_processor_sva.sv
`timescale 1ns/1ns
module scsp_command_processor_sva #(
    parameter int unsigned REC_PERIOD_CYC = 250000000
) (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       rxd,
    input wire logic       txd,
    input wire logic [7:0] regRestart,
    input wire logic [7:0] regDisable,
    input wire logic [7:0] thermRestart,
    input wire logic [7:0] thermDisable,
    input wire logic       adcResetStart,
    input wire logic       adcDisable,
    input wire logic       sysReboot,
    input wire logic       cmdAccepted,
    input wire logic       cmdRejected,
    input wire logic       recordBusy
);
    logic [31:0] sinceRst;
    logic        act;
    // any action pulse at all
    assign act = |{regRestart, regDisable, thermRestart, thermDisable,
                   adcResetStart, adcDisable, sysReboot};
    // saturating age counter, so a long run never wraps into a false early record
    always_ff @(posedge ref_clk) begin
        if (sys_rst) sinceRst <= 32'h0;
        else if (sinceRst != 32'hffffffff) sinceRst <= sinceRst + 32'h1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_oneVerdict;
        !(cmdAccepted && cmdRejected);
    endproperty
    a_oneVerdict: assert property (p_oneVerdict) else $error("both verdicts");
    property p_actValid;
        act |-> cmdAccepted && !cmdRejected;
    endproperty
    a_actValid: assert property (p_actValid) else $error("action without accept");
    property p_regPulse;
        |{regRestart, regDisable} |-> $onehot({regRestart, regDisable}) ##1
            !(|{regRestart, regDisable});
    endproperty
    a_regPulse: assert property (p_regPulse) else $error("regulator pulse");
    property p_thermPulse;
        |{thermRestart, thermDisable} |-> $onehot({thermRestart, thermDisable}) ##1
            !(|{thermRestart, thermDisable});
    endproperty
    a_thermPulse: assert property (p_thermPulse) else $error("thermal pulse");
    property p_adcPulse;
        adcResetStart || adcDisable |-> !(adcResetStart && adcDisable) ##1
            !adcResetStart && !adcDisable;
    endproperty
    a_adcPulse: assert property (p_adcPulse) else $error("adc pulse");
    property p_reboot;
        sysReboot |-> cmdAccepted ##1 !sysReboot;
    endproperty
    a_reboot: assert property (p_reboot) else $error("reboot pulse");
    property p_stopHigh;
        cmdAccepted || cmdRejected |-> rxd && $past(rxd, 8);
    endproperty
    a_stopHigh: assert property (p_stopHigh) else $error("verdict off frame end");
    property p_bitLen;
        $fell(txd) |-> !txd [*8];
    endproperty
    a_bitLen: assert property (p_bitLen) else $error("short start bit");
    property p_recDue;
        $rose(recordBusy) |-> sinceRst >= REC_PERIOD_CYC - 2;
    endproperty
    a_recDue: assert property (p_recDue) else $error("record too early");
endmodule

bind scsp_command_processor scsp_command_processor_sva #(
    .REC_PERIOD_CYC(REC_PERIOD_CYC)
) scsp_command_processor_sva_i (
    .ref_clk, .sys_rst, .rxd, .txd, .regRestart, .regDisable, .thermRestart,
    .thermDisable, .adcResetStart, .adcDisable, .sysReboot, .cmdAccepted,
    .cmdRejected, .recordBusy
);

//--- tb/scsp_platform_model.sv
`timescale 1ns/1ns
module scsp_platform_model #(
    parameter int BIT_CYC = 5208,
    parameter int TX_BIT  = 5208
) (
    input  wire logic ref_clk,
    output logic      rxd,
    input  wire logic txd
);
    logic [7:0] rxq [$];
    logic [7:0] rxByte;
    // mark level between characters, no flow control lines
    initial rxd = 1'b1;
    // start, data lsb first, stop; held a full bit each
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] frm;
        frm = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            rxd <= frm[i];
            repeat (BIT_CYC - 1) @(posedge ref_clk);
        end
    endtask
    // checksum is the caller's business so a bad one can be sent on purpose
    task automatic sendFrame(input logic [7:0] b1, input logic [7:0] b2);
        logic [7:0] f [7];
        f = '{8'h01, 8'h02, b1, b2, 8'h03, 8'h0d, 8'h0a};
        foreach (f[j]) sendByte(f[j]);
    endtask
    // mid-bit sampling of the record stream; bad stop bit drops the byte
    always begin
        @(negedge txd);
        repeat (TX_BIT / 2) @(posedge ref_clk);
        if (txd === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (TX_BIT) @(posedge ref_clk);
                rxByte[i] = txd;
            end
            repeat (TX_BIT) @(posedge ref_clk);
            if (txd === 1'b1) rxq.push_back(rxByte);
        end
    end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [3:0]  pay;
        logic [3:0]  bad;
        logic [7:0]  val;
        logic [36:0] exp;
    } scsp_row_t;
    localparam int REC_CYC = 4000;
    localparam int LIMIT   = 40000;
    logic        refClk, sysRst, rxd, txd, singleEvent, doubleEvent, clr;
    logic [7:0]  regRestart, regDisable, thermRestart, thermDisable;
    logic        adcResetStart, adcDisable, sysReboot, cmdAccepted, cmdRejected;
    logic        recordBusy;
    logic        busySeen = 1'b0;
    logic [36:0] seen;
    int          errCount = 0;
    int          samplesChecked = 0;
    int          cyc = 0;
    // verdict, reg, therm, adc and reboot pulses expected per frame
    scsp_row_t   rows [10] = '{
        '{4'h3, 4'h0, 8'h0d, {2'h2, 8'h20, 24'h0, 3'h0}},
        '{4'h3, 4'h0, 8'h02, {2'h2, 8'h00, 8'h04, 16'h0, 3'h0}},
        '{4'h3, 4'h0, 8'h1f, {2'h2, 16'h0, 8'h80, 8'h00, 3'h0}},
        '{4'h3, 4'h0, 8'h10, {2'h2, 24'h0, 8'h01, 3'h0}},
        '{4'h3, 4'h0, 8'h21, {2'h2, 32'h0, 3'h4}},
        '{4'h3, 4'h0, 8'h20, {2'h2, 32'h0, 3'h2}},
        '{4'h3, 4'h0, 8'hfa, {2'h2, 32'h0, 3'h1}},
        '{4'h3, 4'h0, 8'h55, {2'h2, 32'h0, 3'h0}},
        '{4'h3, 4'h1, 8'h0d, {2'h1, 32'h0, 3'h0}},
        '{4'h5, 4'h0, 8'h0d, {2'h1, 32'h0, 3'h0}}};

    scsp_command_processor #(.REC_PERIOD_CYC(REC_CYC), .TICK_CYC(4)) scsp_command_processor_i (
        .ref_clk      (refClk),
        .sys_rst      (sysRst),
        .rxd          (rxd),
        .payloadId    (4'h3),
        .adcChan      ({8{32'hc3a5_5a3c}}),
        .regVolt      (64'h1111_2222_3333_4444),
        .tempVal      (64'h0a0b_0c0d_0e0f_1011),
        .errCode      (64'h00e1_00e2_00e3_00e4),
        .singleEvent  (singleEvent),
        .doubleEvent  (doubleEvent),
        .txd          (txd),
        .regRestart   (regRestart),
        .regDisable   (regDisable),
        .thermRestart (thermRestart),
        .thermDisable (thermDisable),
        .adcResetStart(adcResetStart),
        .adcDisable   (adcDisable),
        .sysReboot    (sysReboot),
        .cmdAccepted  (cmdAccepted),
        .cmdRejected  (cmdRejected),
        .recordBusy   (recordBusy)
    );
    // short tick of 4 clocks gives a 16-clock bit at both ends
    scsp_platform_model #(.BIT_CYC(16), .TX_BIT(16)) scsp_platform_model_i (
        .ref_clk(refClk),
        .rxd    (rxd),
        .txd    (txd)
    );

    initial begin
        refClk = 1'b0;
        forever #20 refClk = ~refClk;
    end

    task automatic chk(input string name, input logic [63:0] expv, input logic [63:0] got);
        samplesChecked++;
        if (got !== expv) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", name, expv, got);
        end
    endtask

    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // sticky capture of one-cycle pulses; event pulses keep the counters busy
    always @(posedge refClk) begin
        cyc <= cyc + 1;
        singleEvent <= (cyc[3:0] == 4'h0);
        doubleEvent <= (cyc[5:0] == 6'h0);
        if (recordBusy === 1'b1) busySeen <= 1'b1;
        if (clr) seen <= '0;
        else seen <= seen | {cmdAccepted, cmdRejected, regRestart, regDisable,
                             thermRestart, thermDisable, adcResetStart, adcDisable, sysReboot};
        if (cyc == LIMIT) begin
            errCount++;
            reportAndStop();
        end
    end

    initial begin
        sysRst = 1'b1;
        clr = 1'b1;
        repeat (16) @(posedge refClk);
        chk("txdIdle", 64'h1, txd);
        chk("busyInReset", 64'h0, recordBusy);
        sysRst <= 1'b0;
        repeat (8) @(posedge refClk);
        for (int i = 0; i < 10; i++) begin
            clr <= 1'b1;
            @(posedge refClk);
            clr <= 1'b0;
            scsp_platform_model_i.sendFrame({rows[i].pay, rows[i].pay ^ rows[i].bad ^
                rows[i].val[7:4] ^ rows[i].val[3:0]}, rows[i].val);
            repeat (8) @(posedge refClk);
            chk("frameResult", rows[i].exp, seen);
            $display("test %0d done", i);
        end
        chk("recordStarted", 64'h1, busySeen);
        chk("recordBytes", 64'h1, scsp_platform_model_i.rxq.size() >= 4);
        for (int k = 0; k < 4; k++) begin
            chk("firstSeqByte", 64'h0, scsp_platform_model_i.rxq[k]);
        end
        $display("test record done");
        // mid-run reset cuts the record in flight; the next record restarts at sequence 0
        sysRst <= 1'b1;
        repeat (2) @(posedge refClk);
        chk("txdMidReset", 64'h1, txd);
        chk("busyMidReset", 64'h0, recordBusy);
        sysRst <= 1'b0;
        repeat (200) @(posedge refClk);
        scsp_platform_model_i.rxq.delete();
        repeat (REC_CYC + 1000) @(posedge refClk);
        for (int k = 0; k < 4; k++) begin
            chk("seqAfterReset", 64'h0, scsp_platform_model_i.rxq[k]);
        end
        $display("test reset done");
        reportAndStop();
    end
endmodule
